// File: sysbus_map.svh
// Constant map for the processor system bus link
`ifndef SYSBUS_MAP_SVH
`define SYSBUS_MAP_SVH
//------------------------------------------------------------
//------------------------------------------------------------
`define BLK_BYTES 32
`define AD_W 64
`define ADC_W 8
`define ADDR_W 32
`define BLK_DW (`BLK_BYTES * 8 / `AD_W)
`define DW_LSB 3
`define SCLK_DIV 2
`define WB_PAT_LEN 8
`define LEGACY_GAP 2
`define STQ_DEPTH 4
`endif

// File: sysbus_pkg.sv
// Shared types and parity helper for the system bus link
`include "sysbus_map.svh"
package sysbus_pkg;
	// Bus command carried with a valid cycle
	typedef enum logic [1:0] {cmd_read, cmd_write, cmd_bwrite, cmd_data} sys_cmd_t;
	// Kind of a block request from the core
	typedef enum logic {kind_read, kind_write} req_kind_t;
	// Non-block write protocol option
	typedef enum logic [1:0] {wm_legacy, wm_ready, wm_free} wr_mode_t;
	typedef logic [`AD_W-1:0] dword_t;
	typedef logic [`ADC_W-1:0] check_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [1:0] dw_idx_t;
	typedef logic [`BLK_DW-1:0][`AD_W-1:0] block_t;
	// One queued uncached store: address with its doubleword
	typedef struct packed {
		addr_t addr;
		dword_t data;
	} store_t;

	// Even parity, one check bit per byte lane
	function automatic check_t parity_of(input dword_t d);
		check_t p;
		p = '0;
		for (int i = 0; i < `ADC_W; i++) begin
			p[i] = ^d[i*8 +: 8];
		end
		return p;
	endfunction : parity_of
endpackage : sysbus_pkg

// File: sysbus_if.sv
// Link between the processor end and the agent end
`timescale 1ns/1ps
`include "sysbus_map.svh"
interface sysbus_if;
	logic sclk; // Bus clock phase, high on the update edge
	logic dev_oe; // Processor drives the shared bus
	logic [`AD_W-1:0] dev_addr_data;
	logic [`ADC_W-1:0] dev_check_bits;
	logic dev_valid; // Processor cycle carries address or data
	logic [1:0] dev_cmd;
	logic hst_oe; // Agent drives the shared bus
	logic [`AD_W-1:0] hst_addr_data;
	logic [`ADC_W-1:0] hst_check_bits;
	logic hst_valid; // Agent cycle carries read data
	logic hst_err; // Error bit of the data identifier
	logic wr_rdy; // Agent can take a non-block write
	logic slew_loop_out;
	logic slew_loop_in;
	logic compare_fault_out;
	logic [`AD_W-1:0] sys_addr_data_bus;
	logic [`ADC_W-1:0] check_bits_bus;

	// Resolve the shared wires from the two enables
	assign sys_addr_data_bus = dev_oe ? dev_addr_data : (hst_oe ? hst_addr_data : '0);
	assign check_bits_bus = dev_oe ? dev_check_bits : (hst_oe ? hst_check_bits : '0);

	modport dev_mp (output sclk, dev_oe, dev_addr_data, dev_check_bits, dev_valid, dev_cmd,
		output slew_loop_out, compare_fault_out,
		input hst_valid, hst_err, wr_rdy, slew_loop_in, sys_addr_data_bus, check_bits_bus);
	modport host_mp (input sclk, dev_oe, dev_valid, dev_cmd, slew_loop_out, compare_fault_out,
		input sys_addr_data_bus, check_bits_bus,
		output hst_oe, hst_addr_data, hst_check_bits, hst_valid, hst_err, wr_rdy, slew_loop_in);
endinterface : sysbus_if

// File: stq_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module stq_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	// Whole state; ready and valid are kept as flops, not decoded
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
		logic in_rdy;
		logic out_vld;
	} fifo_t;
	fifo_t q, d;
	logic push, pop;

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		d = q;
		push = in_valid_i & q.in_rdy;
		pop = out_ready_i & q.out_vld;
		if (push) begin
			d.mem[q.wr] = in_data_i;
			d.wr = (q.wr == AW'(D - 1)) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + 1'b1;
		end
		d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		// Flags follow the new count so a full queue stalls the source
		d.in_rdy = (d.cnt != (AW + 1)'(D));
		d.out_vld = (d.cnt != '0);
	end

	// State register
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.in_rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign in_ready_o = q.in_rdy;
	assign out_valid_o = q.out_vld;
	assign out_data_o = q.mem[q.rd];
endmodule : stq_fifo

// File: cpu_bus_end.sv
// Processor end of the system bus: stores, block writes, block reads
`timescale 1ns/1ps
`include "sysbus_map.svh"
module cpu_bus_end (
	input wire logic core_clk_i,
	input wire logic srst_i,
	sysbus_if.dev_mp bus,
	input wire sysbus_pkg::wr_mode_t wr_mode_i,
	input wire logic st_valid_i,
	input wire sysbus_pkg::store_t st_data_i,
	output logic st_ready_o,
	input wire logic req_valid_i,
	input wire sysbus_pkg::req_kind_t req_kind_i,
	input wire sysbus_pkg::addr_t req_addr_i,
	input wire sysbus_pkg::block_t req_block_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output sysbus_pkg::dword_t rd_data_o,
	output sysbus_pkg::check_t rd_chk_o,
	output sysbus_pkg::dw_idx_t rd_dw_o,
	output logic rd_par_bad_o,
	output logic cache_err_o,
	output logic bus_err_o,
	output logic rd_done_o
);
	import sysbus_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef enum logic [2:0] {st_idle, st_wdata, st_gap, st_bdata, st_rwait} state_t;

	typedef struct packed {
		state_t st; // Bus sequencer
		logic [1:0] ph; // Divider phase
		logic sclk; // Bus clock, also the update tick
		logic pend; // Block request waiting for the bus
		req_kind_t kind;
		addr_t addr;
		block_t blk;
		store_t cur; // Store being written
		logic [2:0] idx; // Pattern or doubleword counter
		logic [1:0] gap; // Legacy spacing counter
		dword_t ad;
		check_t adc;
		logic oe;
		logic valid;
		sys_cmd_t cmd;
		logic req_ready;
		logic rd_valid;
		dword_t rd_data;
		check_t rd_chk;
		dw_idx_t rd_dw;
		logic rd_bad;
		logic cerr;
		logic berr;
		logic done;
		logic slew;
		logic fault;
	} dev_t;

	dev_t q, d;
	store_t fifo_data; // Head of the store queue
	logic fifo_valid; // Store queue holds an entry
	logic pop; // Take the head store onto the bus
	logic bad; // Parity mismatch on the sampled doubleword
	dw_idx_t dwi; // Doubleword index of the current cycle

	//------------------------------------------------------------
	// Uncached store queue
	//------------------------------------------------------------
	// The queue also serves as the write buffer; it fills while
	// the sequencer is busy and its ready throttles the core
	stq_fifo #(
		.W($bits(store_t)),
		.D(`STQ_DEPTH)
	) u_stq (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.in_valid_i(st_valid_i),
		.in_data_i(st_data_i),
		.in_ready_o(st_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(pop)
	);

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		d = q;
		pop = 1'b0;
		bad = 1'b0;
		dwi = '0;
		d.rd_valid = 1'b0;
		d.cerr = 1'b0;
		d.done = 1'b0;
		// Reserved pins stay high for good
		d.slew = 1'b1;
		d.fault = 1'b1;
		// Bus clock: core clock divided down
		d.ph = (q.ph == 2'(`SCLK_DIV - 1)) ? '0 : q.ph + 1'b1;
		d.sclk = (d.ph == 2'(`SCLK_DIV - 1));
		// Accept a block request on any core cycle while free
		if (q.req_ready && req_valid_i) begin
			d.pend = 1'b1;
			d.kind = req_kind_i;
			d.addr = req_addr_i;
			d.blk = req_block_i;
		end
		if (q.sclk) begin
			case (q.st)
				st_idle: begin
					// Own the bus; no data, so no check bits
					d.oe = 1'b1;
					d.valid = 1'b0;
					d.adc = '0;
					if (q.pend) begin
						// Block requests go ahead of queued stores
						d.pend = 1'b0;
						d.valid = 1'b1;
						d.ad = {{(`AD_W - `ADDR_W){1'b0}}, q.addr};
						d.idx = '0;
						if (q.kind == kind_read) begin
							d.cmd = cmd_read;
							d.berr = 1'b0;
							d.st = st_rwait;
						end else begin
							d.cmd = cmd_bwrite;
							d.st = st_bdata;
						end
					end else if (fifo_valid && (wr_mode_i != wm_ready || bus.wr_rdy)) begin
						// Ready-gated option waits for the agent first
						pop = 1'b1;
						d.cur = fifo_data;
						d.valid = 1'b1;
						d.cmd = cmd_write;
						d.ad = {{(`AD_W - `ADDR_W){1'b0}}, fifo_data.addr};
						d.st = st_wdata;
					end
				end
				st_wdata: begin
					d.valid = 1'b1;
					d.cmd = cmd_data;
					d.ad = q.cur.data;
					d.adc = parity_of(q.cur.data);
					// Fast options leave no gap: one write per two ticks
					if (wr_mode_i == wm_legacy) begin
						d.gap = 2'(`LEGACY_GAP);
						d.st = st_gap;
					end else begin
						d.st = st_idle;
					end
				end
				st_gap: begin
					d.valid = 1'b0;
					d.adc = '0;
					d.gap = q.gap - 1'b1;
					if (q.gap == 2'd1) begin
						d.st = st_idle;
					end
				end
				st_bdata: begin
					// Pattern D D x x D D x x over four doublewords
					dwi = {q.idx[2], q.idx[0]};
					if (!q.idx[1]) begin
						d.valid = 1'b1;
						d.cmd = cmd_data;
						d.ad = q.blk[dwi];
						d.adc = parity_of(q.blk[dwi]);
					end else begin
						// Idle slot: data stays on the wires, no check bits
						d.valid = 1'b0;
						d.adc = '0;
					end
					d.idx = q.idx + 1'b1;
					if (q.idx == 3'(`WB_PAT_LEN - 1)) begin
						d.st = st_idle;
					end
				end
				st_rwait: begin
					// Bus handed over on the tick after the address
					d.oe = 1'b0;
					d.valid = 1'b0;
					d.adc = '0;
					if (bus.hst_valid) begin
						dwi = q.addr[`DW_LSB +: 2] ^ q.idx[1:0];
						bad = (parity_of(bus.sys_addr_data_bus) != bus.check_bits_bus);
						// Data and its received check bits go on as they are
						d.rd_valid = 1'b1;
						d.rd_data = bus.sys_addr_data_bus;
						d.rd_chk = bus.check_bits_bus;
						d.rd_dw = dwi;
						d.rd_bad = bad;
						// Error flags are taken from the addressed doubleword only
						d.cerr = bad && (q.idx == '0);
						if (q.idx == '0) begin
							d.berr = bus.hst_err;
						end
						d.idx = q.idx + 1'b1;
						if (q.idx == 3'(`BLK_DW - 1)) begin
							d.done = 1'b1;
							d.st = st_idle;
						end
					end
				end
				default: begin
					d.st = st_idle;
				end
			endcase
		end
		d.req_ready = ~d.pend;
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.oe <= 1'b1;
			q.req_ready <= 1'b1;
			q.slew <= 1'b1;
			q.fault <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state flops
	assign bus.sclk = q.sclk;
	assign bus.dev_oe = q.oe;
	assign bus.dev_addr_data = q.ad;
	assign bus.dev_check_bits = q.adc;
	assign bus.dev_valid = q.valid;
	assign bus.dev_cmd = q.cmd;
	assign bus.slew_loop_out = q.slew;
	assign bus.compare_fault_out = q.fault;
	assign req_ready_o = q.req_ready;
	assign rd_valid_o = q.rd_valid;
	assign rd_data_o = q.rd_data;
	assign rd_chk_o = q.rd_chk;
	assign rd_dw_o = q.rd_dw;
	assign rd_par_bad_o = q.rd_bad;
	assign cache_err_o = q.cerr;
	assign bus_err_o = q.berr;
	assign rd_done_o = q.done;
endmodule : cpu_bus_end

// File: agent_bus_end.sv
// External agent end of the system bus: takes writes, answers reads
`timescale 1ns/1ps
`include "sysbus_map.svh"
module agent_bus_end (
	input wire logic core_clk_i,
	input wire logic srst_i,
	sysbus_if.host_mp bus,
	input wire logic wr_ready_i,
	output logic wr_valid_o,
	output logic wr_blk_o,
	output sysbus_pkg::addr_t wr_addr_o,
	output sysbus_pkg::dword_t wr_data_o,
	output sysbus_pkg::dw_idx_t wr_dw_o,
	output logic rd_req_o,
	output sysbus_pkg::addr_t rd_addr_o,
	input wire logic resp_valid_i,
	input wire sysbus_pkg::block_t resp_block_i,
	input wire logic resp_err_i,
	output logic resp_ready_o
);
	import sysbus_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef enum logic [2:0] {h_idle, h_wdata, h_bdata, h_rresp, h_rsend} hstate_t;

	typedef struct packed {
		hstate_t st;
		addr_t addr;
		block_t blk; // Read answer being sent
		logic err;
		logic [2:0] idx;
		logic oe;
		logic valid;
		dword_t ad;
		check_t adc;
		logic herr;
		logic wr_rdy;
		logic slew_in;
		logic wr_valid;
		logic wr_blk;
		dword_t wr_data;
		dw_idx_t wr_dw;
		logic rd_req;
		logic resp_ready;
	} hst_t;

	hst_t q, d;
	dw_idx_t dwi; // Doubleword sent in this cycle
	logic dvalid; // Processor shows a valid cycle

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		d = q;
		dwi = '0;
		dvalid = bus.dev_oe && bus.dev_valid;
		d.wr_valid = 1'b0;
		d.rd_req = 1'b0;
		d.slew_in = 1'b1;
		d.wr_rdy = wr_ready_i;
		if (bus.sclk) begin
			case (q.st)
				h_idle: begin
					if (dvalid) begin
						d.addr = bus.sys_addr_data_bus[`ADDR_W-1:0];
						d.idx = '0;
						case (bus.dev_cmd)
							cmd_write: d.st = h_wdata;
							cmd_bwrite: d.st = h_bdata;
							cmd_read: begin
								d.rd_req = 1'b1;
								d.resp_ready = 1'b1;
								d.st = h_rresp;
							end
							default: d.st = h_idle;
						endcase
					end
				end
				h_wdata, h_bdata: begin
					// Idle slots of the writeback pattern are skipped
					if (dvalid && bus.dev_cmd == cmd_data) begin
						d.wr_valid = 1'b1;
						d.wr_blk = (q.st == h_bdata);
						d.wr_data = bus.sys_addr_data_bus;
						d.wr_dw = (q.st == h_bdata) ? q.idx[1:0] : q.addr[`DW_LSB +: 2];
						d.idx = q.idx + 1'b1;
						if (q.st == h_wdata || q.idx == 3'(`BLK_DW - 1)) begin
							d.st = h_idle;
						end
					end
				end
				h_rsend: begin
					if (q.idx == 3'(`BLK_DW)) begin
						// Hand the bus back after the last doubleword
						d.oe = 1'b0;
						d.valid = 1'b0;
						d.herr = 1'b0;
						d.st = h_idle;
					end else begin
						dwi = q.addr[`DW_LSB +: 2] ^ q.idx[1:0];
						d.oe = 1'b1;
						d.valid = 1'b1;
						d.ad = q.blk[dwi];
						d.adc = parity_of(q.blk[dwi]);
						d.herr = q.err && (q.idx == '0);
						d.idx = q.idx + 1'b1;
					end
				end
				default: begin
					d.st = q.st;
				end
			endcase
		end
		// Answer block from the memory side, any core cycle
		if (q.resp_ready && resp_valid_i) begin
			d.blk = resp_block_i;
			d.err = resp_err_i;
			d.resp_ready = 1'b0;
			d.idx = '0;
			d.st = h_rsend;
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.slew_in <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state flops
	assign bus.hst_oe = q.oe;
	assign bus.hst_addr_data = q.ad;
	assign bus.hst_check_bits = q.adc;
	assign bus.hst_valid = q.valid;
	assign bus.hst_err = q.herr;
	assign bus.wr_rdy = q.wr_rdy;
	assign bus.slew_loop_in = q.slew_in;
	assign wr_valid_o = q.wr_valid;
	assign wr_blk_o = q.wr_blk;
	assign wr_addr_o = q.addr;
	assign wr_data_o = q.wr_data;
	assign wr_dw_o = q.wr_dw;
	assign rd_req_o = q.rd_req;
	assign rd_addr_o = q.addr;
	assign resp_ready_o = q.resp_ready;
endmodule : agent_bus_end

// File: sysbus_checker.sv
// Concurrent checks on the wires between the processor end and the agent end
`timescale 1ns/1ps
`include "sysbus_map.svh"
module sysbus_checker (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic dev_oe,
	input wire logic [`AD_W-1:0] dev_addr_data,
	input wire logic [`ADC_W-1:0] dev_check_bits,
	input wire logic dev_valid,
	input wire logic [1:0] dev_cmd,
	input wire logic hst_valid,
	input wire logic hst_err,
	input wire logic slew_loop_out,
	input wire logic slew_loop_in,
	input wire logic compare_fault_out
);
	//------------------------------------------------
	// Helpers
	//------------------------------------------------
	logic dat; // Processor data cycle on the bus
	assign dat = dev_oe && dev_valid && dev_cmd == 2'd3;
	// Even parity per byte lane, kept apart from the design's helper
	function automatic logic [7:0] lane_par(input logic [63:0] d);
		for (int i = 0; i < 8; i++) begin
			lane_par[i] = ^d[i*8 +: 8];
		end
	endfunction : lane_par
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	//------------------------------------------------
	// Assertions
	//------------------------------------------------
	a_slew_out_high: assert property (slew_loop_out == 1'b1)
		else $error("slew loop output not high");
	a_fault_out_high: assert property (compare_fault_out == 1'b1)
		else $error("compare fault output not high");
	a_slew_in_high: assert property (slew_loop_in == 1'b1)
		else $error("slew loop input not high");
	a_nodata_check_zero: assert property (dev_oe && !dat |-> dev_check_bits == 8'h00)
		else $error("check bits not zero outside data");
	a_data_parity_ok: assert property (dat |-> dev_check_bits == lane_par(dev_addr_data))
		else $error("check bits do not match data parity");
	a_bwrite_data_next: assert property (dev_valid && dev_cmd == 2'd2 |-> ##[1:2] dat)
		else $error("block write data does not follow address");
	// First pair of data, then idle ticks that hold the last data value
	a_wb_idle_hold: assert property (
		$rose(dev_valid && dev_cmd == 2'd2) |->
		##2 dat [*4] ##1 (!dev_valid && $stable(dev_addr_data)) [*4] ##1 dat)
		else $error("writeback idle cycles lost last data");
	// Second pair of data, then the trailing idle ticks
	a_wb_tail_shape: assert property (
		$rose(dev_valid && dev_cmd == 2'd2) |->
		##10 dat [*4] ##1 (!dev_valid && dev_check_bits == 8'h00) [*4])
		else $error("writeback pattern broken");
	a_read_release_now: assert property (dev_valid && dev_cmd == 2'd0 |-> ##[1:2] !dev_oe)
		else $error("bus not released after read");
	c_bwrite: cover property ($rose(dev_valid && dev_cmd == 2'd2));
	c_single: cover property (dev_valid && dev_cmd == 2'd1);
	c_read: cover property (dev_valid && dev_cmd == 2'd0);
	c_err: cover property (hst_valid && hst_err);
endmodule : sysbus_checker

// File: tb_cpu_system_bus_interface.sv
// Self-checking bench: processor end and agent end joined by the bus
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_cpu_system_bus_interface;
	import sysbus_pkg::*;
	//------------------------------------------------
	// Signals
	//------------------------------------------------
	logic core_clk_i, srst_i, st_valid_i, st_ready_o, req_valid_i, req_ready_o;
	wr_mode_t wr_mode_i;
	store_t st_data_i;
	req_kind_t req_kind_i;
	addr_t req_addr_i, wr_addr_o, rd_addr_o, ra;
	block_t req_block_i, resp_block_i;
	logic rd_valid_o, rd_par_bad_o, cache_err_o, bus_err_o, rd_done_o;
	dword_t rd_data_o, wr_data_o;
	check_t rd_chk_o;
	dw_idx_t rd_dw_o, wr_dw_o;
	logic wr_ready_i, wr_valid_o, wr_blk_o, rd_req_o, resp_valid_i, resp_err_i, resp_ready_o;
	int fail_count = 0;
	int check_count = 0;
	int seed = 32'hb644;
	int cyc = 0; // Core cycle stamp for spacing checks
	typedef struct {logic blk; addr_t a; dword_t d; dw_idx_t i; int t;} wrec_t;
	typedef struct {dword_t d; check_t c; dw_idx_t i; logic pb, ce, dn;} rrec_t;
	wrec_t wq[$]; // Writes seen at the agent's user side
	rrec_t rq[$]; // Doublewords seen at the processor's user side
	sysbus_if sysbus_if_inst ();
	cpu_bus_end cpu_bus_end_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(sysbus_if_inst),
		.wr_mode_i(wr_mode_i), .st_valid_i(st_valid_i), .st_data_i(st_data_i),
		.st_ready_o(st_ready_o), .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
		.req_addr_i(req_addr_i), .req_block_i(req_block_i), .req_ready_o(req_ready_o),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_chk_o(rd_chk_o), .rd_dw_o(rd_dw_o),
		.rd_par_bad_o(rd_par_bad_o), .cache_err_o(cache_err_o), .bus_err_o(bus_err_o),
		.rd_done_o(rd_done_o));
	agent_bus_end agent_bus_end_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.bus(sysbus_if_inst), .wr_ready_i(wr_ready_i), .wr_valid_o(wr_valid_o),
		.wr_blk_o(wr_blk_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_dw_o(wr_dw_o),
		.rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .resp_valid_i(resp_valid_i),
		.resp_block_i(resp_block_i), .resp_err_i(resp_err_i), .resp_ready_o(resp_ready_o));
	sysbus_checker sysbus_checker_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.dev_oe(sysbus_if_inst.dev_oe), .dev_addr_data(sysbus_if_inst.dev_addr_data),
		.dev_check_bits(sysbus_if_inst.dev_check_bits), .dev_valid(sysbus_if_inst.dev_valid),
		.dev_cmd(sysbus_if_inst.dev_cmd), .hst_valid(sysbus_if_inst.hst_valid),
		.hst_err(sysbus_if_inst.hst_err), .slew_loop_out(sysbus_if_inst.slew_loop_out),
		.slew_loop_in(sysbus_if_inst.slew_loop_in),
		.compare_fault_out(sysbus_if_inst.compare_fault_out));
	//------------------------------------------------
	// Clock and monitors
	//------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Registered pulses are sampled one edge after they were launched
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (wr_valid_o === 1'b1) wq.push_back('{wr_blk_o, wr_addr_o, wr_data_o, wr_dw_o, cyc});
		if (rd_valid_o === 1'b1) begin
			rq.push_back('{rd_data_o, rd_chk_o, rd_dw_o, rd_par_bad_o, cache_err_o, rd_done_o});
		end
		if (rd_req_o === 1'b1) ra <= rd_addr_o;
	end
	//------------------------------------------------
	// Tasks
	//------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	// A wait that ran out is a mismatch and ends the run
	task automatic tmo(input int n);
		if (n >= 400) begin
			fail_count++;
			$display("Error at %0t: wait got %h limit %h", $time, n, 400);
			wrap_up();
		end
	endtask : tmo
	function automatic dword_t rnd_dw();
		return {$random(seed), $random(seed)};
	endfunction : rnd_dw
	// Expected check bits: even parity over each byte lane
	function automatic check_t exp_par(input dword_t d);
		check_t p;
		for (int i = 0; i < 8; i++) p[i] = ^d[i*8 +: 8];
		return p;
	endfunction : exp_par
	// Sub-block order: index of the k-th doubleword from the addressed start
	function automatic dw_idx_t exp_dw(input addr_t a, input int k);
		return a[4:3] ^ dw_idx_t'(k);
	endfunction : exp_dw
	task automatic wait_q(input int want, input bit rd);
		int n;
		n = 0;
		while (((rd ? rq.size() : wq.size()) < want) && n < 400) begin
			@(negedge core_clk_i);
			n++;
		end
		tmo(n);
	endtask : wait_q
	// Hold the request until ready is sampled high at an edge
	task automatic blk_req(input req_kind_t k, input addr_t a, input block_t b);
		int n;
		n = 0;
		req_kind_i = k;
		req_addr_i = a;
		req_block_i = b;
		req_valid_i = 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 400);
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		tmo(n);
	endtask : blk_req
	task automatic do_bwr(input addr_t a);
		block_t b;
		for (int k = 0; k < 4; k++) b[k] = rnd_dw();
		wq.delete();
		blk_req(kind_write, a, b);
		wait_q(4, 0);
		for (int k = 0; k < 4; k++) begin
			`CHK(wq[k].blk, 1'b1)
			`CHK(wq[k].a, a)
			`CHK(wq[k].i, dw_idx_t'(k))
			`CHK(wq[k].d, b[k])
			if (k > 0) `CHK(wq[k].t - wq[k-1].t, (k == 2) ? 6 : 2)
		end
		`CHK(wq[1].t - wq[0].t, 2)
	endtask : do_bwr
	task automatic do_read(input addr_t a, input logic e);
		block_t b;
		int n;
		dw_idx_t x;
		for (int k = 0; k < 4; k++) b[k] = rnd_dw();
		rq.delete();
		blk_req(kind_read, a, '0);
		resp_block_i = b;
		resp_err_i = e;
		resp_valid_i = 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (resp_ready_o !== 1'b1 && n < 400);
		@(negedge core_clk_i);
		resp_valid_i = 1'b0;
		tmo(n);
		wait_q(4, 1);
		`CHK(ra, a)
		for (int k = 0; k < 4; k++) begin
			x = exp_dw(a, k);
			`CHK(rq[k].i, x)
			`CHK(rq[k].d, b[x])
			`CHK(rq[k].c, exp_par(b[x]))
			`CHK(rq[k].dn, (k == 3))
			`CHK(({rq[k].pb, rq[k].ce}), 2'b00)
		end
		`CHK(bus_err_o, e)
	endtask : do_read
	// Stores in one write mode; the ready mode first fills the queue until refused
	task automatic do_st(input wr_mode_t m);
		store_t s[$];
		wr_mode_i = m;
		wr_ready_i = (m != wm_ready);
		wq.delete();
		for (int n = 0; n < 5; n++) begin
			st_data_i.addr = $random(seed) & 32'hffff_fff8;
			st_data_i.data = rnd_dw();
			st_valid_i = 1'b1;
			@(posedge core_clk_i);
			if (st_ready_o === 1'b1) s.push_back(st_data_i);
			@(negedge core_clk_i);
		end
		st_valid_i = 1'b0;
		if (m == wm_ready) `CHK(s.size(), 4)
		wr_ready_i = 1'b1;
		wait_q(s.size(), 0);
		for (int k = 0; k < s.size(); k++) begin
			`CHK(({wq[k].blk, wq[k].a, wq[k].d}), ({1'b0, s[k].addr, s[k].data}))
			`CHK(wq[k].i, s[k].addr[4:3])
			if (k > 0) `CHK(wq[k].t - wq[k-1].t, (m == wm_legacy) ? 8 : 4)
		end
	endtask : do_st
	//------------------------------------------------
	// Main sequence
	//------------------------------------------------
	initial begin
		srst_i = 1'b1;
		wr_mode_i = wm_free;
		st_valid_i = 1'b0;
		st_data_i = '0;
		req_valid_i = 1'b0;
		req_kind_i = kind_read;
		req_addr_i = '0;
		req_block_i = '0;
		wr_ready_i = 1'b1;
		resp_valid_i = 1'b0;
		resp_block_i = '0;
		resp_err_i = 1'b0;
		repeat (3) @(negedge core_clk_i);
		srst_i = 1'b0;
		`CHK(({req_ready_o, st_ready_o}), 2'b11)
		`CHK(sysbus_if_inst.slew_loop_out, 1'b1)
		`CHK(sysbus_if_inst.compare_fault_out, 1'b1)
		`CHK(sysbus_if_inst.slew_loop_in, 1'b1)
		$display("test reset done");
		for (int k = 0; k < 3; k++) do_bwr($random(seed) & 32'hffff_ffe0);
		$display("test block_write done");
		// Every sub-block start, error flag on odd starts
		for (int k = 0; k < 4; k++) do_read(($random(seed) & 32'hffff_ffe0) | (k << 3), k[0]);
		$display("test block_read done");
		do_st(wm_ready);
		do_st(wm_free);
		do_st(wm_legacy);
		$display("test store done");
		wrap_up();
	end
endmodule : tb_cpu_system_bus_interface
